//--- hw/dllr_pkg.sv
package dllr_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_COARSE_CFG  = 8'h5a;
  localparam logic [7:0] ADDR_FINE_CFG    = 8'h5b;
  localparam logic [7:0] ADDR_HOLD_CFG    = 8'h5c;
  localparam logic [7:0] ADDR_HOLD_B0     = 8'h5d;
  localparam logic [7:0] ADDR_HOLD_B1     = 8'h5e;
  localparam logic [7:0] ADDR_HOLD_B2     = 8'h5f;
  localparam logic [7:0] ADDR_AUX_SRC     = 8'h60;
  localparam logic [7:0] ADDR_FREQ_B0     = 8'h62;
  localparam logic [7:0] ADDR_FREQ_B1     = 8'h63;
  localparam logic [7:0] ADDR_FREQ_B2     = 8'h64;
  localparam logic [7:0] ADDR_SOFT_LIM    = 8'h65;
  localparam logic [7:0] ADDR_HARD_LO     = 8'h66;
  localparam logic [7:0] ADDR_HARD_HI     = 8'h67;
  localparam logic [7:0] ADDR_PHASE_LO    = 8'h68;
  localparam logic [7:0] ADDR_PHASE_HI    = 8'h69;
  localparam logic [7:0] ADDR_BW_CFG      = 8'h6a;
  // ==========================================================
  // Field positions
  localparam int BIT_COARSE_EN    = 7;
  localparam int BIT_WIDE_EN      = 6;
  localparam int BIT_PFD_RANGE    = 5;
  localparam int BIT_LOW_RATE_EN  = 4;
  localparam int BIT_FINE_EN      = 7;
  localparam int BIT_MANUAL       = 7;
  localparam int BIT_AVERAGING    = 6;
  localparam int BIT_FAST_AVERAGING_SEL     = 5;
  localparam int BIT_READBACK     = 4;
  localparam int BIT_HARD_UNLOCK  = 7;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_COARSE_CFG = 8'h80;
  localparam logic [7:0] RST_FINE_CFG   = 8'h82;
  localparam logic [7:0] RST_HOLD_CFG   = 8'h44;
  localparam logic [7:0] RST_AUX_SRC    = 8'h00;
  localparam logic [7:0] RST_SOFT_LIM   = 8'h8c;
  localparam logic [7:0] RST_HARD_LO    = 8'h00;
  localparam logic [7:0] RST_HARD_HI    = 8'h00;
  localparam logic [7:0] RST_BW_CFG     = 8'h11;
  // Writable bit masks
  localparam logic [7:0] MASK_FINE_CFG  = 8'hc7;
  localparam logic [7:0] MASK_HOLD_CFG  = 8'hfc;
  localparam logic [7:0] MASK_AUX_SRC   = 8'hf0;
  localparam logic [7:0] MASK_BW_CFG    = 8'h33;
  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    DLLR_HOLD_INSTANT = 2'b00,
    DLLR_HOLD_SLOW    = 2'b01,
    DLLR_HOLD_FAST    = 2'b11,
    DLLR_HOLD_MANUAL  = 2'b10
  } dllr_hold_method_t;
  typedef enum logic [1:0] {
    DLLR_SNAP_IDLE = 2'b00,
    DLLR_SNAP_HELD = 2'b01
  } dllr_snap_state_t;
  localparam logic [3:0] AUX_SRC_MAX    = 4'h3;
  localparam logic [3:0] PFD_UNIT_LIMIT = 4'h0;
endpackage

//--- hw/dllr_snap_if.sv
`timescale 1ns/1ps
interface dllr_snap_if;
  logic        capture;
  logic [23:0] freq;
  logic [15:0] phase;
  modport owner (output capture, input freq, input phase);
  modport store (input capture, output freq, output phase);
endinterface

//--- hw/dllr_snapshot.sv
`timescale 1ns/1ps
// ==========================================================
// Coherent capture of multi-byte status
module dllr_snapshot (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic [23:0] i_freq,
  input  wire logic [15:0] i_phase,
  dllr_snap_if.store       snap
);
  logic [23:0] freq;
  logic [15:0] phase;
  logic [23:0] next_freq;
  logic [15:0] next_phase;

  always_comb begin
    next_freq  = freq;
    next_phase = phase;
    if (snap.capture) begin
      next_freq  = i_freq;
      next_phase = i_phase;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      freq  <= 24'h000000;
      phase <= 16'h0000;
    end else begin
      freq  <= next_freq;
      phase <= next_phase;
    end
  end

  assign snap.freq  = freq;
  assign snap.phase = phase;
endmodule // dllr_snapshot

//--- hw/dllr_regs.sv
`timescale 1ns/1ps
// What this block does
// - Coarse loss unlocks loop when enabled
// - Range select picks 1 UI or coarse limit
// - Low-rate inputs need both enables for threshold
// - Other inputs use wide enable only
// - Fine loss unlocks loop when enabled
// - 24-bit signed holdover offset, manual value
// - Aux loop source field; codes above 3 flag reserved
// - Hard alarm unlocks loop when enabled
// - Hard threshold 16-bit unsigned, symmetric
// - Averaged phase error 16-bit read-only
// - Two-bit bandwidth fields for both loops
module dllr_regs (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_addr,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_low_rate_input,
  input  wire logic        i_coarse_loss,
  input  wire logic        i_fine_loss,
  input  wire logic        i_hard_alarm,
  input  wire logic [23:0] i_avg_offset_slow,
  input  wire logic [23:0] i_avg_offset_fast,
  input  wire logic [23:0] i_current_freq,
  input  wire logic [15:0] i_avg_phase_error,
  output logic             o_unlock,
  output logic             o_pfd_wide_limit,
  output logic      [3:0]  o_pfd_limit_code,
  output logic      [2:0]  o_fine_loss_threshold,
  output logic             o_fast_loss_switch,
  output logic      [1:0]  o_holdover_method,
  output logic      [1:0]  o_temp_holdover_method,
  output logic      [23:0] o_holdover_offset_value,
  output logic      [3:0]  o_aux_loop_source,
  output logic             o_aux_source_reserved,
  output logic      [6:0]  o_soft_freq_threshold,
  output logic      [15:0] o_hard_freq_threshold,
  output logic      [1:0]  o_main_analog_loop_bw,
  output logic      [1:0]  o_aux_analog_loop_bw
);
  // ==========================================================
  // Configuration storage
  logic [7:0]  coarse_cfg;
  logic [7:0]  fine_cfg;
  logic [7:0]  hold_cfg;
  logic [23:0] holdover_offset_value;
  logic [7:0]  aux_src;
  logic [7:0]  soft_lim;
  logic [7:0]  hard_lo;
  logic [7:0]  hard_hi;
  logic [7:0]  bw_cfg;
  logic [7:0]  next_coarse_cfg;
  logic [7:0]  next_fine_cfg;
  logic [7:0]  next_hold_cfg;
  logic [23:0] next_holdover_offset_value;
  logic [7:0]  next_aux_src;
  logic [7:0]  next_soft_lim;
  logic [7:0]  next_hard_lo;
  logic [7:0]  next_hard_hi;
  logic [7:0]  next_bw_cfg;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  always_comb begin
    next_coarse_cfg            = coarse_cfg;
    next_fine_cfg              = fine_cfg;
    next_hold_cfg              = hold_cfg;
    next_holdover_offset_value = holdover_offset_value;
    next_aux_src               = aux_src;
    next_soft_lim              = soft_lim;
    next_hard_lo               = hard_lo;
    next_hard_hi               = hard_hi;
    next_bw_cfg                = bw_cfg;
    if (i_wr) begin
      if (hit(i_addr, dllr_pkg::ADDR_COARSE_CFG)) next_coarse_cfg = i_wdata;
      if (hit(i_addr, dllr_pkg::ADDR_FINE_CFG))
        next_fine_cfg = i_wdata & dllr_pkg::MASK_FINE_CFG;
      if (hit(i_addr, dllr_pkg::ADDR_HOLD_CFG))
        next_hold_cfg = i_wdata & dllr_pkg::MASK_HOLD_CFG;
      if (hit(i_addr, dllr_pkg::ADDR_HOLD_B0))
        next_holdover_offset_value[7:0] = i_wdata;
      if (hit(i_addr, dllr_pkg::ADDR_HOLD_B1))
        next_holdover_offset_value[15:8] = i_wdata;
      if (hit(i_addr, dllr_pkg::ADDR_HOLD_B2))
        next_holdover_offset_value[23:16] = i_wdata;
      if (hit(i_addr, dllr_pkg::ADDR_AUX_SRC))
        next_aux_src = i_wdata & dllr_pkg::MASK_AUX_SRC;
      if (hit(i_addr, dllr_pkg::ADDR_SOFT_LIM)) next_soft_lim = i_wdata;
      if (hit(i_addr, dllr_pkg::ADDR_HARD_LO)) next_hard_lo = i_wdata;
      if (hit(i_addr, dllr_pkg::ADDR_HARD_HI)) next_hard_hi = i_wdata;
      if (hit(i_addr, dllr_pkg::ADDR_BW_CFG))
        next_bw_cfg = i_wdata & dllr_pkg::MASK_BW_CFG;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      coarse_cfg            <= dllr_pkg::RST_COARSE_CFG;
      fine_cfg              <= dllr_pkg::RST_FINE_CFG;
      hold_cfg              <= dllr_pkg::RST_HOLD_CFG;
      holdover_offset_value <= 24'h000000;
      aux_src               <= dllr_pkg::RST_AUX_SRC;
      soft_lim              <= dllr_pkg::RST_SOFT_LIM;
      hard_lo               <= dllr_pkg::RST_HARD_LO;
      hard_hi               <= dllr_pkg::RST_HARD_HI;
      bw_cfg                <= dllr_pkg::RST_BW_CFG;
    end else begin
      coarse_cfg            <= next_coarse_cfg;
      fine_cfg              <= next_fine_cfg;
      hold_cfg              <= next_hold_cfg;
      holdover_offset_value <= next_holdover_offset_value;
      aux_src               <= next_aux_src;
      soft_lim              <= next_soft_lim;
      hard_lo               <= next_hard_lo;
      hard_hi               <= next_hard_hi;
      bw_cfg                <= next_bw_cfg;
    end
  end

  // ==========================================================
  // Status snapshot control
  dllr_snap_if             snap_bus ();
  dllr_pkg::dllr_snap_state_t snap_state;
  dllr_pkg::dllr_snap_state_t next_snap_state;
  logic                    freq_low_read;
  logic                    phase_low_read;
  logic                    status_high_read;
  logic                    snap_held;

  assign freq_low_read    = i_rd && hit(i_addr, dllr_pkg::ADDR_FREQ_B0);
  assign phase_low_read   = i_rd && hit(i_addr, dllr_pkg::ADDR_PHASE_LO);
  assign status_high_read = i_rd && (hit(i_addr, dllr_pkg::ADDR_FREQ_B2)
                                  || hit(i_addr, dllr_pkg::ADDR_PHASE_HI));

  // Low byte read freezes a sample; upper bytes then come from it
  always_comb begin
    next_snap_state = snap_state;
    unique case (snap_state)
      dllr_pkg::DLLR_SNAP_IDLE: begin
        if (freq_low_read || phase_low_read) next_snap_state = dllr_pkg::DLLR_SNAP_HELD;
      end
      dllr_pkg::DLLR_SNAP_HELD: begin
        if (status_high_read) next_snap_state = dllr_pkg::DLLR_SNAP_IDLE;
      end
      default: next_snap_state = dllr_pkg::DLLR_SNAP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      snap_state <= dllr_pkg::DLLR_SNAP_IDLE;
    end else begin
      snap_state <= next_snap_state;
    end
  end

  // Re-capture on every low-byte read, never mid-sequence otherwise
  assign snap_bus.capture = freq_low_read || phase_low_read;
  assign snap_held        = (snap_state == dllr_pkg::DLLR_SNAP_HELD);

  dllr_snapshot u_snapshot (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_freq    (i_current_freq),
    .i_phase   (i_avg_phase_error),
    .snap      (snap_bus.store)
  );

  // ==========================================================
  // Read path
  logic [23:0] offset_readback;
  logic [7:0]  next_rdata;
  logic [23:0] freq_view;
  logic [15:0] phase_view;

  // Upper bytes come from the frozen sample only while a sequence is open
  assign freq_view  = (snap_held && !freq_low_read) ? snap_bus.freq
                                                    : i_current_freq;
  assign phase_view = (snap_held && !phase_low_read) ? snap_bus.phase
                                                     : i_avg_phase_error;

  always_comb begin
    if (!hold_cfg[dllr_pkg::BIT_READBACK])
      offset_readback = holdover_offset_value;
    else if (hold_cfg[dllr_pkg::BIT_FAST_AVERAGING_SEL])
      offset_readback = i_avg_offset_fast;
    else
      offset_readback = i_avg_offset_slow;
  end

  always_comb begin
    next_rdata = 8'h00;
    unique case (i_addr)
      dllr_pkg::ADDR_COARSE_CFG: next_rdata = coarse_cfg;
      dllr_pkg::ADDR_FINE_CFG:   next_rdata = fine_cfg;
      dllr_pkg::ADDR_HOLD_CFG:   next_rdata = hold_cfg;
      dllr_pkg::ADDR_HOLD_B0:    next_rdata = offset_readback[7:0];
      dllr_pkg::ADDR_HOLD_B1:    next_rdata = offset_readback[15:8];
      dllr_pkg::ADDR_HOLD_B2:    next_rdata = offset_readback[23:16];
      dllr_pkg::ADDR_AUX_SRC:    next_rdata = aux_src;
      dllr_pkg::ADDR_FREQ_B0:    next_rdata = freq_view[7:0];
      dllr_pkg::ADDR_FREQ_B1:    next_rdata = freq_view[15:8];
      dllr_pkg::ADDR_FREQ_B2:    next_rdata = freq_view[23:16];
      dllr_pkg::ADDR_SOFT_LIM:   next_rdata = soft_lim;
      dllr_pkg::ADDR_HARD_LO:    next_rdata = hard_lo;
      dllr_pkg::ADDR_HARD_HI:    next_rdata = hard_hi;
      dllr_pkg::ADDR_PHASE_LO:   next_rdata = phase_view[7:0];
      dllr_pkg::ADDR_PHASE_HI:   next_rdata = phase_view[15:8];
      dllr_pkg::ADDR_BW_CFG:     next_rdata = bw_cfg;
      default:                   next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= o_rdata;
    end
  end

  // ==========================================================
  // Loop control decode
  logic       coarse_threshold_active;
  logic       next_unlock;
  logic       next_pfd_wide_limit;
  logic [3:0] next_pfd_limit_code;
  logic [1:0] next_holdover_method;
  logic       next_aux_source_reserved;

  always_comb begin
    if (i_low_rate_input)
      coarse_threshold_active = coarse_cfg[dllr_pkg::BIT_LOW_RATE_EN]
                             && coarse_cfg[dllr_pkg::BIT_WIDE_EN];
    else
      coarse_threshold_active = coarse_cfg[dllr_pkg::BIT_WIDE_EN];
  end

  always_comb begin
    next_unlock = 1'b0;
    if (i_coarse_loss && coarse_cfg[dllr_pkg::BIT_COARSE_EN]) next_unlock = 1'b1;
    if (i_fine_loss && fine_cfg[dllr_pkg::BIT_FINE_EN]) next_unlock = 1'b1;
    if (i_hard_alarm && soft_lim[dllr_pkg::BIT_HARD_UNLOCK]) next_unlock = 1'b1;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_unlock <= 1'b0;
    end else begin
      o_unlock <= next_unlock;
    end
  end

  assign next_pfd_wide_limit = coarse_cfg[dllr_pkg::BIT_PFD_RANGE]
                            && coarse_threshold_active;
  assign next_pfd_limit_code = next_pfd_wide_limit ? coarse_cfg[3:0]
                                                   : dllr_pkg::PFD_UNIT_LIMIT;
  assign o_fine_loss_threshold  = fine_cfg[2:0];
  assign o_fast_loss_switch     = fine_cfg[6];
  assign o_temp_holdover_method = hold_cfg[3:2];

  always_comb begin
    if (hold_cfg[dllr_pkg::BIT_MANUAL])
      next_holdover_method = dllr_pkg::DLLR_HOLD_MANUAL;
    else if (!hold_cfg[dllr_pkg::BIT_AVERAGING])
      next_holdover_method = dllr_pkg::DLLR_HOLD_INSTANT;
    else if (hold_cfg[dllr_pkg::BIT_FAST_AVERAGING_SEL])
      next_holdover_method = dllr_pkg::DLLR_HOLD_FAST;
    else
      next_holdover_method = dllr_pkg::DLLR_HOLD_SLOW;
  end

  assign o_holdover_offset_value = holdover_offset_value;
  assign o_aux_loop_source       = aux_src[7:4];
  assign next_aux_source_reserved = aux_src[7:4] > dllr_pkg::AUX_SRC_MAX;
  assign o_soft_freq_threshold   = soft_lim[6:0];
  assign o_hard_freq_threshold   = {hard_hi, hard_lo};
  assign o_main_analog_loop_bw   = bw_cfg[5:4];
  assign o_aux_analog_loop_bw    = bw_cfg[1:0];

  // Decoded controls leave through flip-flops like the raw fields
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_pfd_wide_limit      <= 1'b0;
      o_pfd_limit_code      <= dllr_pkg::PFD_UNIT_LIMIT;
      o_holdover_method     <= dllr_pkg::DLLR_HOLD_SLOW;
      o_aux_source_reserved <= 1'b0;
    end else begin
      o_pfd_wide_limit      <= next_pfd_wide_limit;
      o_pfd_limit_code      <= next_pfd_limit_code;
      o_holdover_method     <= next_holdover_method;
      o_aux_source_reserved <= next_aux_source_reserved;
    end
  end
endmodule // dllr_regs

//--- sim/dllr_regs_properties.sv
`timescale 1ns/1ps
// ==========================================================
// Port-level checks for the loop register bank
module dllr_regs_checker (
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  input wire logic [7:0]  i_addr,
  input wire logic        i_wr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic        i_low_rate_input,
  input wire logic        i_coarse_loss,
  input wire logic        i_fine_loss,
  input wire logic        i_hard_alarm,
  input wire logic        o_unlock,
  input wire logic        o_pfd_wide_limit,
  input wire logic [3:0]  o_pfd_limit_code,
  input wire logic [1:0]  o_holdover_method,
  input wire logic [23:0] o_holdover_offset_value,
  input wire logic [3:0]  o_aux_loop_source,
  input wire logic        o_aux_source_reserved,
  input wire logic [1:0]  o_main_analog_loop_bw,
  input wire logic [1:0]  o_aux_analog_loop_bw
);
  logic [7:0] sh_coarse;
  logic [7:0] sh_hold;
  logic       sh_fine;
  logic       sh_hard;
  logic       loss_hit;
  logic       wide_exp;
  logic [3:0] code_exp;
  logic [1:0] method_exp;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // Shadow of enable and holdover-method fields, tracked from bus writes
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sh_coarse <= 8'h80;
      sh_hold   <= 8'h44;
      sh_fine   <= 1'b1;
      sh_hard   <= 1'b1;
    end else if (i_wr) begin
      if (i_addr == 8'h5a) sh_coarse <= i_wdata;
      if (i_addr == 8'h5c) sh_hold <= i_wdata;
      if (i_addr == 8'h5b) sh_fine <= i_wdata[7];
      if (i_addr == 8'h65) sh_hard <= i_wdata[7];
    end
  end
  assign loss_hit = (i_coarse_loss & sh_coarse[7]) | (i_fine_loss & sh_fine)
                  | (i_hard_alarm & sh_hard);
  assign wide_exp = sh_coarse[5] & sh_coarse[6] & (sh_coarse[4] | !i_low_rate_input);
  assign code_exp = wide_exp ? sh_coarse[3:0] : 4'h0;
  assign method_exp = sh_hold[7] ? 2'b10 : (sh_hold[6] ? {sh_hold[5], 1'b1} : 2'b00);
  // ==========================================================
  // Properties
  property p_unlock_set; loss_hit |=> o_unlock; endproperty
  a_unlock_set: assert property (p_unlock_set) else $error("unlock missing");
  property p_unlock_clr; !loss_hit |=> !o_unlock; endproperty
  a_unlock_clr: assert property (p_unlock_clr) else $error("stray unlock");
  property p_pfd_wide; o_pfd_wide_limit == $past(wide_exp); endproperty
  a_pfd_wide: assert property (p_pfd_wide) else $error("pfd range wrong");
  property p_pfd_code; o_pfd_limit_code == $past(code_exp); endproperty
  a_pfd_code: assert property (p_pfd_code) else $error("pfd limit code wrong");
  property p_method; o_holdover_method == $past(method_exp); endproperty
  a_method: assert property (p_method) else $error("holdover method wrong");
  property p_offset; i_wr && i_addr == 8'h5f |=> o_holdover_offset_value[23:16] == $past(i_wdata);
  endproperty
  a_offset: assert property (p_offset) else $error("offset byte not stored");
  property p_aux_res; o_aux_source_reserved == ($past(o_aux_loop_source) > 4'h3); endproperty
  a_aux_res: assert property (p_aux_res) else $error("reserved flag wrong");
  property p_bw;
    i_wr && i_addr == 8'h6a |=> o_main_analog_loop_bw == $past(i_wdata[5:4])
      && o_aux_analog_loop_bw == $past(i_wdata[1:0]);
  endproperty
  a_bw: assert property (p_bw) else $error("bandwidth field wrong");
  property p_unmapped; i_rd && i_addr == 8'h61 |=> o_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_unlock: cover property (o_unlock);
  c_low_wide: cover property (o_pfd_wide_limit && i_low_rate_input);
  c_reserved: cover property (o_aux_source_reserved);
endmodule // dllr_regs_checker

bind dllr_regs dllr_regs_checker i_checker (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr), .i_wr(i_wr),
  .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata), .i_low_rate_input(i_low_rate_input),
  .i_coarse_loss(i_coarse_loss), .i_fine_loss(i_fine_loss), .i_hard_alarm(i_hard_alarm),
  .o_unlock(o_unlock), .o_pfd_wide_limit(o_pfd_wide_limit), .o_pfd_limit_code(o_pfd_limit_code),
  .o_holdover_method(o_holdover_method), .o_holdover_offset_value(o_holdover_offset_value),
  .o_aux_loop_source(o_aux_loop_source), .o_aux_source_reserved(o_aux_source_reserved),
  .o_main_analog_loop_bw(o_main_analog_loop_bw), .o_aux_analog_loop_bw(o_aux_analog_loop_bw)
);

//--- sim/dllr_regs_tb_top.sv
`timescale 1ns/1ps
module dllr_regs_tb_top;
  logic        i_clk_sys, i_reset, i_wr, i_rd, i_low_rate_input;
  logic        i_coarse_loss, i_fine_loss, i_hard_alarm, o_unlock;
  logic        o_pfd_wide_limit, o_fast_loss_switch, o_aux_source_reserved;
  logic [1:0]  o_holdover_method, o_temp_holdover_method, o_main_analog_loop_bw;
  logic [1:0]  o_aux_analog_loop_bw;
  logic [2:0]  o_fine_loss_threshold;
  logic [3:0]  o_pfd_limit_code, o_aux_loop_source;
  logic [6:0]  o_soft_freq_threshold;
  logic [7:0]  i_addr, i_wdata, o_rdata;
  logic [15:0] i_avg_phase_error, o_hard_freq_threshold;
  logic [23:0] i_avg_offset_slow, i_avg_offset_fast, i_current_freq, o_holdover_offset_value;
  int          fail_count, tests_run;
  logic [7:0]  ra [11] = '{8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h65, 8'h66,
                           8'h67, 8'h6a};
  logic [7:0]  rv [11] = '{8'h80, 8'h82, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00, 8'h8c,
                           8'h00, 8'h00, 8'h11};
  logic [7:0]  rm [11] = '{8'hff, 8'hc7, 8'hfc, 8'hff, 8'hff, 8'hff, 8'hf0, 8'hff, 8'hff,
                           8'hff, 8'h33};

  dllr_regs i_dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr), .i_wr(i_wr),
    .i_wdata(i_wdata), .i_rd(i_rd), .o_rdata(o_rdata), .i_low_rate_input(i_low_rate_input),
    .i_coarse_loss(i_coarse_loss), .i_fine_loss(i_fine_loss), .i_hard_alarm(i_hard_alarm),
    .i_avg_offset_slow(i_avg_offset_slow), .i_avg_offset_fast(i_avg_offset_fast),
    .i_current_freq(i_current_freq), .i_avg_phase_error(i_avg_phase_error),
    .o_unlock(o_unlock), .o_pfd_wide_limit(o_pfd_wide_limit),
    .o_pfd_limit_code(o_pfd_limit_code), .o_fine_loss_threshold(o_fine_loss_threshold),
    .o_fast_loss_switch(o_fast_loss_switch), .o_holdover_method(o_holdover_method),
    .o_temp_holdover_method(o_temp_holdover_method),
    .o_holdover_offset_value(o_holdover_offset_value), .o_aux_loop_source(o_aux_loop_source),
    .o_aux_source_reserved(o_aux_source_reserved),
    .o_soft_freq_threshold(o_soft_freq_threshold), .o_hard_freq_threshold(o_hard_freq_threshold),
    .o_main_analog_loop_bw(o_main_analog_loop_bw), .o_aux_analog_loop_bw(o_aux_analog_loop_bw)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // ==========================================================
  // Shared bus and compare tasks
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    i_addr  = a;
    i_wdata = d;
    i_wr    = 1'b1;
    @(posedge i_clk_sys);
    #1;
    i_wr = 1'b0;
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_addr = a;
    i_rd   = 1'b1;
    @(posedge i_clk_sys);
    #1;
    i_rd = 1'b0;
    check(o_rdata, exp);
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic close_out;
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    check({o_holdover_method, o_main_analog_loop_bw, o_aux_analog_loop_bw}, 6'h15);
    check({o_fine_loss_threshold, o_fast_loss_switch, o_temp_holdover_method}, 6'h11);
    for (int i = 0; i < 11; i++) rd_chk(ra[i], rv[i]);
    for (int i = 0; i < 11; i++) begin
      reg_wr(ra[i], 8'hff);
      rd_chk(ra[i], rm[i]);
      reg_wr(ra[i], 8'h00);
      rd_chk(ra[i], 8'h00);
    end
    reg_wr(8'h61, 8'hff);
    rd_chk(8'h61, 8'h00);
    rd_chk(8'h6b, 8'h00);
  endtask
  task automatic t_unlock;
    for (int i = 0; i < 64; i++) begin
      reg_wr(8'h5a, {i[0], 7'h00});
      reg_wr(8'h5b, {i[1], 7'h02});
      reg_wr(8'h65, {i[2], 7'h0c});
      {i_hard_alarm, i_fine_loss, i_coarse_loss} = i[5:3];
      @(posedge i_clk_sys);
      #1;
      check(o_unlock, (i[0] & i[3]) | (i[1] & i[4]) | (i[2] & i[5]));
    end
    {i_hard_alarm, i_fine_loss, i_coarse_loss} = 3'h0;
  endtask
  task automatic t_pfd;
    logic wide;
    for (int i = 0; i < 16; i++) begin
      reg_wr(8'h5a, {1'b1, i[1], i[0], i[2], 4'h9});
      i_low_rate_input = i[3];
      @(posedge i_clk_sys);
      #1;
      wide = i[0] & i[1] & (i[2] | !i[3]);
      check(o_pfd_wide_limit, wide);
      check(o_pfd_limit_code, wide ? 4'h9 : 4'h0);
    end
  endtask
  task automatic t_hold;
    for (int i = 0; i < 8; i++) begin
      reg_wr(8'h5c, {i[2:0], 5'h00});
      check(o_holdover_method, i[2] ? 2'b10 : (i[1] ? {i[0], 1'b1} : 2'b00));
    end
    reg_wr(8'h5d, 8'h01);
    reg_wr(8'h5e, 8'h80);
    reg_wr(8'h5f, 8'hff);
    check(o_holdover_offset_value, 24'hff8001);
    rd_chk(8'h5f, 8'hff);
    reg_wr(8'h5c, 8'h10);
    rd_chk(8'h5e, 8'h34);
    rd_chk(8'h5f, 8'h12);
    reg_wr(8'h5c, 8'h30);
    rd_chk(8'h5d, 8'hba);
    check(o_holdover_offset_value, 24'hff8001);
  endtask
  task automatic t_status;
    reg_wr(8'h62, 8'h55);
    rd_chk(8'h62, 8'hef);
    i_current_freq = 24'h010203;
    rd_chk(8'h63, 8'hcd);
    rd_chk(8'h64, 8'hab);
    rd_chk(8'h68, 8'h23);
    i_avg_phase_error = 16'h7fff;
    rd_chk(8'h69, 8'h81);
  endtask
  task automatic t_fields;
    for (int i = 0; i < 5; i++) begin
      reg_wr(8'h60, {i[3:0], 4'hf});
      check({o_aux_source_reserved, o_aux_loop_source}, {i > 3, i[3:0]});
    end
    reg_wr(8'h65, 8'hab);
    check(o_soft_freq_threshold, 7'h2b);
    reg_wr(8'h66, 8'hfe);
    reg_wr(8'h67, 8'h81);
    check(o_hard_freq_threshold, 16'h81fe);
    reg_wr(8'h5b, 8'h45);
    reg_wr(8'h5c, 8'h08);
    check({o_fine_loss_threshold, o_fast_loss_switch, o_temp_holdover_method}, 6'h2e);
    for (int i = 0; i < 4; i++) begin
      reg_wr(8'h6a, {2'b11, i[1:0], 2'b11, ~i[1:0]});
      check({o_main_analog_loop_bw, o_aux_analog_loop_bw}, {i[1:0], ~i[1:0]});
    end
  endtask

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    fail_count++;
    close_out;
  end
  initial begin
    fail_count = 0;
    tests_run = 0;
    i_reset = 1'b1;
    {i_wr, i_rd, i_addr, i_wdata, i_low_rate_input} = '0;
    {i_coarse_loss, i_fine_loss, i_hard_alarm} = 3'h0;
    i_avg_offset_slow = 24'h123456;
    i_avg_offset_fast = 24'hfedcba;
    i_current_freq = 24'habcdef;
    i_avg_phase_error = 16'h8123;
    repeat (10) @(posedge i_clk_sys);
    #1;
    i_reset = 1'b0;
    t_regs;
    t_unlock;
    t_pfd;
    t_hold;
    t_status;
    t_fields;
    close_out;
  end
endmodule // dllr_regs_tb_top
